//--- hw/sic_map.svh
/*
  Constants of the serial channel: reset values and bit timing counts.
  Assumes inclusion by bare name from the channel's design files.
*/
`ifndef SIC_MAP_SVH
`define SIC_MAP_SVH
`define SIC_DIV_RESET   8'h07
`define SIC_PRE_LAST    3'h7
`define SIC_UART_LAST   4'hF
`define SIC_SYNC_LAST   4'h1
`define SIC_UART_MID    4'h7
`define SIC_BIT_LAST    3'h7
`define SIC_TX_EMPTY_RESET 1'b1
`endif

//--- hw/sic_pkg.sv
/*
  Types of the serial channel: transmitter and receiver states.
  Assumes nothing of its surroundings.
*/
package sic_pkg;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} sic_tx_state_type;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} sic_rx_state_type;
endpackage : sic_pkg

//--- hw/sic_baud_divider.sv
/*
  Baud divider: counts the divisor down and pulses a tick at each count end.
  Assumes clk_i is the bus clock and that the divisor strobe is synchronous to it.
*/
`include "sic_map.svh"
module sic_baud_divider (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  wire logic       idle_i,
  input  wire logic       src_i,
  input  wire logic       div_wr_i,
  input  wire logic [7:0] div_i,
  output logic            tick_o
);
  logic [2:0] pre;
  logic [7:0] cnt;
  logic [7:0] cur;
  wire        src_en  = src_i ? (pre == `SIC_PRE_LAST) : 1'b1;
  wire        cnt_end = src_en && (cnt == 8'h00);
  wire        now_wr  = div_wr_i && idle_i;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pre    <= 3'h0;
      cnt    <= `SIC_DIV_RESET;
      cur    <= `SIC_DIV_RESET;
      tick_o <= 1'b0;
    end else if (ce_i) begin
      pre    <= pre + 3'h1;
      tick_o <= cnt_end;
      if (div_wr_i) cur <= div_i;
      if (now_wr) cnt <= div_i; // [R04]
      else if (cnt_end) cnt <= div_wr_i ? div_i : cur; // [R04]
      else if (src_en) cnt <= cnt - 8'h01;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_div_defer;
    ce_i && div_wr_i && !idle_i && src_en && !cnt_end |=> cnt == $past(cnt) - 8'h01;
  endproperty
  a_div_defer: assert property (p_div_defer) else $error("Divisor applied mid count."); // [R04]

  property p_div_now;
    ce_i && now_wr |=> cnt == $past(div_i) && cur == $past(div_i);
  endproperty
  a_div_now: assert property (p_div_now) else $error("Idle divisor write not immediate."); // [R04]
endmodule : sic_baud_divider

//--- hw/sic_serial_channel.sv
/*
  Serial channel with clocked serial mode and UART mode, receive flags and
  transfer controller requests. Control and status are plain ports.
  Assumes one bus clock, rxd_i asynchronous, and strobes one cycle wide.
*/
// Notes on behaviour
// R01 - Software changes mode, divisor and source only with both enables cleared.
// R02 - Clocked serial bit rate from the bus clock stays at or below 2 Mbps.
// R03 - In UART mode with bus clock source the divisor is at least seven.
// R04 - A divisor write takes effect after the running count, immediately when idle.
// R05 - For back-to-back sends, load the next word before the current ends.
// R06 - Clocked serial receive shifts only while the transmitter sends a word.
// R07 - With the pin selector at one, the dummy word appears on the output pin.
// R08 - For back-to-back clocked receive, load the next dummy word early.
// R09 - The transfer controller is set up before serial traffic starts.
// R10 - A word completing while the buffer is full flags overrun and is dropped.
// R11 - After overrun reception continues, status stays set, nothing reaches the buffer.
// R12 - Only clearing the receive enable clears overrun and restarts reception.
// R13 - Clocked mode after overrun: buffer reads do not clear receive finished.
// R14 - UART mode exposes status, finished, error sum, overrun, parity, framing.
// R15 - Without overrun, a buffer read or enable clear clears finished and errors.
// R16 - After overrun, finished and errors clear only by clearing the enable.
// R17 - Transmit request stands while the buffer is empty and transmit is enabled.
// R18 - Receive request follows receive finished, suppressed after an overrun.
// R19 - Finished sets on buffer load; error sum ORs overrun, parity, framing.
`include "sic_map.svh"
module sic_serial_channel (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  wire logic       clocked_serial_mode_i,
  input  wire logic       tx_en_i,
  input  wire logic       rx_en_i,
  input  wire logic       div_src_i,
  input  wire logic       div_wr_i,
  input  wire logic [7:0] div_i,
  input  wire logic       parity_en_i,
  input  wire logic       parity_odd_i,
  input  wire logic       pin_sel_i,
  input  wire logic       txbuf_wr_i,
  input  wire logic [7:0] txbuf_data_i,
  input  wire logic       rxbuf_rd_i,
  input  wire logic       rxd_i,
  output logic            txd_o,
  output logic            txd_oe_n_o,
  output logic            sclk_o,
  output logic [7:0]      rx_data_o,
  output logic            tx_buf_empty_o,
  output logic            rx_status_o,
  output logic            rx_finished_o,
  output logic            err_sum_o,
  output logic            overrun_o,
  output logic            parity_err_o,
  output logic            framing_err_o,
  output logic            dma_tx_req_o,
  output logic            dma_rx_req_o
);
  sic_pkg::sic_tx_state_type tx_state;
  sic_pkg::sic_tx_state_type next_tx_state;
  sic_pkg::sic_rx_state_type rx_state;
  sic_pkg::sic_rx_state_type next_rx_state;
  logic       tick;
  logic       rxd_m;
  logic       rxd_s;
  logic       rxd_d;
  logic [7:0] tx_buf;
  logic [7:0] tx_shift;
  logic       tx_par;
  logic [3:0] tcnt;
  logic [2:0] tbit;
  logic [7:0] rx_shift;
  logic [3:0] rcnt;
  logic [2:0] rbit;
  logic       rx_perr;

  sic_baud_divider u_div (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .ce_i     (ce_i),
    .idle_i   (!tx_en_i && !rx_en_i),
    .src_i    (div_src_i),
    .div_wr_i (div_wr_i),
    .div_i    (div_i),
    .tick_o   (tick)
  );

  wire sync_mode = clocked_serial_mode_i;
  wire tx_last   = tcnt == (sync_mode ? `SIC_SYNC_LAST : `SIC_UART_LAST);
  // Starting only on a tick keeps the first bit a full bit long, at the cost of
  // up to one tick of extra idle line between words.
  wire tx_start  = tick && tx_state == sic_pkg::TX_IDLE && tx_en_i && !tx_buf_empty_o;
  wire tx_step   = tick && tx_state != sic_pkg::TX_IDLE && tx_last;
  wire in_data   = tx_state == sic_pkg::TX_DATA;
  wire sync_smp  = sync_mode && rx_en_i && tick && in_data && tcnt == 4'h0;
  wire sync_done = sync_smp && tbit == `SIC_BIT_LAST;
  wire rx_fall   = rxd_d && !rxd_s;
  wire rx_step   = tick && rcnt == (rx_state == sic_pkg::RX_START ? `SIC_UART_MID
                                                                  : `SIC_UART_LAST);
  wire uart_done = rx_step && rx_state == sic_pkg::RX_STOP;
  wire word_done = sync_done || uart_done;
  wire [7:0] word_data = sync_mode ? {rxd_s, rx_shift[7:1]} : rx_shift;
  wire accept    = rx_en_i && word_done && !rx_finished_o && !overrun_o;
  wire ovr_evt   = word_done && (rx_finished_o || overrun_o);
  wire clear_rd  = rxbuf_rd_i && !overrun_o;
  wire next_txd  = tx_state == sic_pkg::TX_START ? 1'b0 :
                   in_data ? tx_shift[0] :
                   tx_state == sic_pkg::TX_PARITY ? tx_par : 1'b1;
  wire next_sclk = !(sync_mode && in_data && tcnt == 4'h0);
  wire next_tx_empty = txbuf_wr_i ? 1'b0 : (tx_start ? 1'b1 : tx_buf_empty_o);
  wire next_finished = rx_en_i && (accept || (rx_finished_o && !clear_rd));
  wire next_overrun  = rx_en_i && (overrun_o || ovr_evt);
  wire next_perr = rx_en_i && (accept ? (!sync_mode && parity_en_i && rx_perr)
                                      : (parity_err_o && !clear_rd));
  wire next_ferr = rx_en_i && (accept ? (!sync_mode && !rxd_s)
                                      : (framing_err_o && !clear_rd));
  wire rx_active = rx_state != sic_pkg::RX_IDLE || (sync_mode && in_data);
  wire next_status = rx_en_i && (next_overrun || rx_active);

  always_comb begin
    next_tx_state = tx_state;
    unique case (tx_state)
      sic_pkg::TX_IDLE:   if (tx_start) next_tx_state = sync_mode ? sic_pkg::TX_DATA
                                                              : sic_pkg::TX_START;
      sic_pkg::TX_START:  if (tx_step) next_tx_state = sic_pkg::TX_DATA;
      sic_pkg::TX_DATA:   if (tx_step && tbit == `SIC_BIT_LAST) begin
        next_tx_state = sync_mode ? sic_pkg::TX_IDLE
                             : (parity_en_i ? sic_pkg::TX_PARITY : sic_pkg::TX_STOP);
      end
      sic_pkg::TX_PARITY: if (tx_step) next_tx_state = sic_pkg::TX_STOP;
      sic_pkg::TX_STOP:   if (tx_step) next_tx_state = sic_pkg::TX_IDLE;
      default:            next_tx_state = sic_pkg::TX_IDLE;
    endcase
  end

  // The receiver watches the line only in UART mode; clocked mode rides the transmitter.
  always_comb begin
    next_rx_state = rx_state;
    unique case (rx_state)
      sic_pkg::RX_IDLE:   if (!sync_mode && rx_fall) next_rx_state = sic_pkg::RX_START;
      sic_pkg::RX_START:  if (rx_step) next_rx_state = rxd_s ? sic_pkg::RX_IDLE
                                                              : sic_pkg::RX_DATA;
      sic_pkg::RX_DATA:   if (rx_step && rbit == `SIC_BIT_LAST) begin
        next_rx_state = parity_en_i ? sic_pkg::RX_PARITY : sic_pkg::RX_STOP;
      end
      sic_pkg::RX_PARITY: if (rx_step) next_rx_state = sic_pkg::RX_STOP;
      sic_pkg::RX_STOP:   if (rx_step) next_rx_state = sic_pkg::RX_IDLE;
      default:            next_rx_state = sic_pkg::RX_IDLE;
    endcase
    if (!rx_en_i) next_rx_state = sic_pkg::RX_IDLE;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rxd_m <= 1'b1;
      rxd_s <= 1'b1;
      rxd_d <= 1'b1;
    end else if (ce_i) begin
      rxd_m <= rxd_i;
      rxd_s <= rxd_m;
      rxd_d <= rxd_s;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_state <= sic_pkg::TX_IDLE;
      tx_buf   <= 8'h00;
      tx_shift <= 8'h00;
      tx_par   <= 1'b0;
      tcnt     <= 4'h0;
      tbit     <= 3'h0;
    end else if (ce_i) begin
      tx_state <= next_tx_state;
      if (txbuf_wr_i) tx_buf <= txbuf_data_i;
      if (tx_start) begin
        tx_shift <= tx_buf;
        tx_par   <= ^tx_buf ^ parity_odd_i;
        tcnt     <= 4'h0;
        tbit     <= 3'h0;
      end else if (tick && tx_state != sic_pkg::TX_IDLE) begin
        tcnt <= tx_last ? 4'h0 : tcnt + 4'h1;
        if (tx_step && in_data) begin
          tx_shift <= {1'b1, tx_shift[7:1]};
          tbit     <= tbit + 3'h1;
        end
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_state <= sic_pkg::RX_IDLE;
      rx_shift <= 8'h00;
      rcnt     <= 4'h0;
      rbit     <= 3'h0;
      rx_perr  <= 1'b0;
    end else if (ce_i) begin
      rx_state <= next_rx_state;
      if (sync_smp) rx_shift <= {rxd_s, rx_shift[7:1]}; // [R06]
      if (rx_state == sic_pkg::RX_IDLE || rx_step) rcnt <= 4'h0;
      else if (tick) rcnt <= rcnt + 4'h1;
      if (rx_state == sic_pkg::RX_IDLE) begin
        rbit    <= 3'h0;
        rx_perr <= 1'b0;
      end else if (rx_step && rx_state == sic_pkg::RX_DATA) begin
        rx_shift <= {rxd_s, rx_shift[7:1]};
        rbit     <= rbit + 3'h1;
      end else if (rx_step && rx_state == sic_pkg::RX_PARITY) begin
        rx_perr <= rxd_s ^ (^rx_shift) ^ parity_odd_i;
      end
    end
  end

  // Flags: a word finishing in the cycle of a clearing read is dropped as an overrun; the read still clears finished and the errors.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      txd_o          <= 1'b1;
      txd_oe_n_o     <= 1'b1;
      sclk_o         <= 1'b1;
      rx_data_o      <= 8'h00;
      tx_buf_empty_o <= `SIC_TX_EMPTY_RESET;
      rx_status_o    <= 1'b0;
      rx_finished_o  <= 1'b0;
      err_sum_o      <= 1'b0;
      overrun_o      <= 1'b0;
      parity_err_o   <= 1'b0;
      framing_err_o  <= 1'b0;
      dma_tx_req_o   <= 1'b0;
      dma_rx_req_o   <= 1'b0;
    end else if (ce_i) begin
      txd_o          <= next_txd; // [R07]
      txd_oe_n_o     <= !pin_sel_i; // [R07]
      sclk_o         <= next_sclk; // [R06]
      if (accept) rx_data_o <= word_data; // [R10] [R11]
      tx_buf_empty_o <= next_tx_empty;
      rx_status_o    <= next_status; // [R11] [R14]
      rx_finished_o  <= next_finished; // [R13] [R15] [R16] [R19]
      overrun_o      <= next_overrun; // [R10] [R12]
      parity_err_o   <= next_perr; // [R15] [R16]
      framing_err_o  <= next_ferr; // [R15] [R16]
      err_sum_o      <= next_overrun || next_perr || next_ferr; // [R19]
      dma_tx_req_o   <= next_tx_empty && tx_en_i; // [R17]
      dma_rx_req_o   <= next_finished && !next_overrun; // [R18]
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_ovr_hit;
    ce_i && rx_en_i && word_done && rx_finished_o;
  endsequence
  sequence s_ovr_kept;
    overrun_o && rx_data_o == $past(rx_data_o);
  endsequence

  property p_ovr_drop;
    s_ovr_hit |=> s_ovr_kept;
  endproperty
  a_ovr_drop: assert property (p_ovr_drop) else $error("Overrun word reached buffer."); // [R10]

  property p_ovr_sticky;
    ce_i && overrun_o && rx_en_i |=> overrun_o && rx_status_o && $stable(rx_data_o);
  endproperty
  a_ovr_sticky: assert property (p_ovr_sticky) else $error("Overrun state lost."); // [R11]

  property p_en_clear;
    ce_i && !rx_en_i |=> !overrun_o && !rx_finished_o && !parity_err_o && !framing_err_o;
  endproperty
  a_en_clear: assert property (p_en_clear) else $error("Enable clear left a flag."); // [R12]

  property p_rd_ignored;
    ce_i && overrun_o && rx_en_i && rxbuf_rd_i |=> $stable(rx_finished_o);
  endproperty
  a_rd_ignored: assert property (p_rd_ignored) else $error("Read cleared after overrun."); // [R13]

  property p_rd_clears;
    ce_i && rx_en_i && rxbuf_rd_i && !overrun_o && !word_done
      |=> !rx_finished_o && !parity_err_o && !framing_err_o;
  endproperty
  a_rd_clears: assert property (p_rd_clears) else $error("Read did not clear flags."); // [R15]

  property p_err_sum;
    err_sum_o == (overrun_o || parity_err_o || framing_err_o);
  endproperty
  a_err_sum: assert property (p_err_sum) else $error("Error sum mismatch."); // [R19]

  property p_accept;
    ce_i && accept |=> rx_finished_o && rx_data_o == $past(word_data);
  endproperty
  a_accept: assert property (p_accept) else $error("Word not loaded to buffer."); // [R19]

  property p_tx_req;
    ce_i |=> dma_tx_req_o == (tx_buf_empty_o && $past(tx_en_i));
  endproperty
  a_tx_req: assert property (p_tx_req) else $error("Transmit request wrong."); // [R17]

  property p_rx_req;
    dma_rx_req_o == (rx_finished_o && !overrun_o);
  endproperty
  a_rx_req: assert property (p_rx_req) else $error("Receive request wrong."); // [R18]

  property p_sync_rx;
    sync_mode && !in_data |-> !word_done;
  endproperty
  a_sync_rx: assert property (p_sync_rx) else $error("Clocked receive without send."); // [R06]

  property p_pin;
    ce_i && pin_sel_i |=> !txd_oe_n_o;
  endproperty
  a_pin: assert property (p_pin) else $error("Output pin not driven."); // [R07]
endmodule : sic_serial_channel

//--- verif/sic_peer.sv
/*
  Serial peer model that drives the channel's receive line.
  Assumes a pull-up on the line, so a released line reads high.
*/
module sic_peer (
  input  wire logic clk_i,
  input  wire logic sclk_i,
  input  wire logic clocked_i,
  output logic      rxd_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] word;
  int         idx = 8;
  initial rxd_o = 1'b1;
  // The bit changes on the falling shift clock so it is stable at the sampling rise.
  always @(negedge sclk_i) begin
    if (clocked_i && idx < 8) begin
      rxd_o <= word[idx];
      idx   <= idx + 1;
    end
  end
  task automatic load(input logic [7:0] w);
    word = w;
    idx  = 0;
  endtask : load
  task automatic release_line;
    rxd_o = 1'b1;
  endtask : release_line
  task automatic put(input logic b, input int n);
    #1 rxd_o = b;
    repeat (n) @(posedge clk_i);
  endtask : put
  task automatic send(input logic [7:0] w, input logic pe, input logic pb,
                      input logic stop, input int bc);
    @(posedge clk_i);
    put(1'b0, bc);
    for (int i = 0; i < 8; i++) put(w[i], bc);
    if (pe) put(pb, bc);
    // A bad stop bit is held low just past the receiver's mid-bit stop sample, then cut short; the line goes high for a full bit.
    if (!stop) put(1'b0, bc * 5 / 8);
    put(1'b1, bc);
  endtask : send
endmodule : sic_peer

//--- verif/sic_serial_channel_test.sv
/*
  Self-checking bench of the serial channel with the serial peer model.
  Assumes both compile first; inputs change 1 ns after the rising edge.
*/
module sic_serial_channel_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, mode = 1'b0, tx_en = 1'b0;
  logic       rx_en = 1'b0, div_src = 1'b0, div_wr = 1'b0, par_en = 1'b0, par_odd = 1'b0;
  logic       pin_sel = 1'b0, txbuf_wr = 1'b0, rxbuf_rd = 1'b0, rxd, txd, txd_oe_n, sclk;
  logic       tx_empty, rx_status, rx_fin, err_sum, overrun, par_err, frm_err, dma_tx, dma_rx;
  logic [7:0] div = 8'h07, tx_data = 8'h00, rx_data, w, d, r0, got;
  int         err_total = 0, checks = 0, bc;
  always #25 clk_i = ~clk_i;
  sic_serial_channel i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .clocked_serial_mode_i(mode), .tx_en_i(tx_en), .rx_en_i(rx_en), .div_src_i(div_src),
    .div_wr_i(div_wr), .div_i(div), .parity_en_i(par_en), .parity_odd_i(par_odd),
    .pin_sel_i(pin_sel), .txbuf_wr_i(txbuf_wr), .txbuf_data_i(tx_data),
    .rxbuf_rd_i(rxbuf_rd), .rxd_i(rxd), .txd_o(txd), .txd_oe_n_o(txd_oe_n), .sclk_o(sclk),
    .rx_data_o(rx_data), .tx_buf_empty_o(tx_empty), .rx_status_o(rx_status),
    .rx_finished_o(rx_fin), .err_sum_o(err_sum), .overrun_o(overrun),
    .parity_err_o(par_err), .framing_err_o(frm_err), .dma_tx_req_o(dma_tx),
    .dma_rx_req_o(dma_rx));
  sic_peer i_peer (.clk_i(clk_i), .sclk_i(sclk), .clocked_i(mode), .rxd_o(rxd));
  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask : pulse
  function automatic int bit_cyc(input logic src, input logic [7:0] dv);
    return 16 * (dv + 1) * (src ? 8 : 1);
  endfunction : bit_cyc
  function automatic logic par_of(input logic [7:0] v, input logic odd);
    return ^v ^ odd;
  endfunction : par_of
  task automatic set_div(input logic src, input logic [7:0] dv);
    div_src = src;
    div     = dv;
    pulse(div_wr);
  endtask : set_div
  task automatic wait_fin;
    for (int i = 0; i < 4000 && rx_fin !== 1'b1; i++) tick(1);
  endtask : wait_fin
  task automatic tx_uart(input logic [7:0] v, input bit more, input logic [7:0] nxt);
    int n = 0;
    for (int i = 0; i < 4000 && txd !== 1'b0; i++) tick(1);
    while (txd === 1'b0 && n < 4000) begin
      n++;
      tick(1);
    end
    chk(8'(n == bc), 8'h01);
    if (more) begin
      tx_data = nxt;
      pulse(txbuf_wr);
    end
    for (int i = 0; i < 8; i++) begin
      tick(i == 0 ? bc / 2 : bc);
      got[i] = txd;
    end
    tick(bc);
    chk(got, v);
    chk(txd, 1'b1);
    // The last word of a run is let finish so that settings may change afterwards.
    if (!more) tick(bc);
  endtask : tx_uart
  initial begin
    void'($urandom(32'h738A25EB));
    tick(12);
    rst_i = 1'b0;
    chk({tx_empty, txd, sclk, txd_oe_n, rx_fin, overrun, dma_tx, dma_rx}, 8'hF0);
    pin_sel = 1'b1;
    for (int k = 0; k < 2; k++) begin
      tx_en = 1'b0;
      set_div(k[0], k ? 8'h01 : 8'h07);
      bc = bit_cyc(k[0], div);
      chk(dma_tx, 1'b0);
      tx_en = 1'b1;
      tick(2);
      chk({dma_tx, txd_oe_n}, 8'h02);
      w = 8'($urandom) | 8'h01;
      d = 8'($urandom) | 8'h01;
      tx_data = w;
      pulse(txbuf_wr);
      tx_uart(w, k == 0, d);
      if (k == 0) tx_uart(d, 1'b0, 8'h00);
    end
    tx_en = 1'b0;
    set_div(1'b0, 8'h07);
    bc = bit_cyc(1'b0, div);
    rx_en = 1'b1;
    // Cases 0..3 cover every parity setting, 4 a parity error, 5 a framing error.
    for (int k = 0; k < 6; k++) begin
      w = 8'($urandom);
      par_en = k[0] | k[2];
      par_odd = k[1];
      i_peer.send(w, par_en, par_of(w, par_odd) ^ (k == 4), k != 5, bc);
      wait_fin;
      chk({rx_fin, dma_rx, err_sum, par_err, frm_err}, {2'b11, k > 3, k == 4, k == 5});
      chk(rx_data, w);
      pulse(rxbuf_rd);
      tick(1);
      chk({rx_fin, err_sum, par_err, frm_err}, 8'h00);
    end
    par_en = 1'b0;
    w = 8'($urandom);
    i_peer.send(w, 1'b0, 1'b0, 1'b1, bc);
    wait_fin;
    i_peer.send(~w, 1'b0, 1'b0, 1'b1, bc);
    tick(4);
    chk({overrun, err_sum, rx_status, dma_rx}, 8'h0E);
    i_peer.send(8'h5A, 1'b0, 1'b0, 1'b1, bc);
    chk(rx_data, w);
    chk(rx_status, 1'b1);
    pulse(rxbuf_rd);
    tick(1);
    chk({rx_fin, overrun}, 8'h03);
    rx_en = 1'b0;
    tick(2);
    chk({rx_fin, overrun, err_sum, rx_status}, 8'h00);
    rx_en = 1'b1;
    i_peer.send(~w, 1'b0, 1'b0, 1'b1, bc);
    wait_fin;
    chk(rx_data, ~w);
    chk(overrun, 1'b0);
    rx_en = 1'b0;
    mode = 1'b1;
    tick(2);
    tx_en = 1'b1;
    rx_en = 1'b1;
    tick(200);
    chk(rx_fin, 1'b0);
    for (int k = 0; k < 2; k++) begin
      w = 8'($urandom);
      d = 8'($urandom);
      if (k == 0) r0 = w;
      i_peer.load(w);
      tx_data = d;
      pulse(txbuf_wr);
      for (int i = 0; i < 8; i++) begin
        @(posedge sclk);
        got[i] = txd;
      end
      tick(40);
      i_peer.release_line;
      chk(got, d);
      chk(rx_data, r0);
      chk({rx_fin, overrun}, {1'b1, k[0]});
    end
    pulse(rxbuf_rd);
    tick(1);
    chk(rx_fin, 1'b1);
    rx_en = 1'b0;
    tick(2);
    chk({rx_fin, overrun}, 8'h00);
    give_verdict;
  end
  initial begin
    repeat (60000) @(posedge clk_i);
    err_total++;
    give_verdict;
  end
endmodule : sic_serial_channel_test
